// file: verilog/pltc_pkg.sv
// Contract
// - counter steps by one each timer tick
// - only counting, not writes, raises value events
// - clear zeroes count, prescaler and direction
// - software count write takes effect immediately
// - length selects 8, 10, 12, 16 bit maximum
// - short lengths store written count right-aligned
// - source select picks one of four clocks
// - selected clock divided by 1, 2, 4, 8
// - counts only when mode nonzero and clock active
// - zero period halts; nonzero restarts from zero
// - up mode counts zero to period, wraps
// - count above period in up restarts zero
// - up mode channel and rollover flag timing
// - period change while running extends or wraps
// - continuous counts to maximum, wraps, flags rollover
// - continuous ignores period; channel zero plain compare
// - up/down counts to period and back
// - up/down direction latched; only clear or a zero period resets it
// - up/down flags once per period each; a period of one never flags rollover
// - up/down period above maximum acts as continuous
// - load code zero copies channel write at once
package pltc_pkg;
   localparam int unsigned CNT_W = 16;

   // register byte offsets
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_COUNT  = 12'h004;
   localparam logic [11:0] OFF_CH0    = 12'h008;
   localparam logic [11:0] OFF_PERIOD = 12'h00C;
   localparam logic [11:0] OFF_STATUS = 12'h010;

   // control field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_DIV_LSB  = 2;
   localparam int unsigned CTRL_SRC_LSB  = 4;
   localparam int unsigned CTRL_LEN_LSB  = 6;
   localparam int unsigned CTRL_CLR_BIT  = 8;
   localparam int unsigned CTRL_RIE_BIT  = 9;
   localparam int unsigned CTRL_CIE_BIT  = 10;
   localparam int unsigned CTRL_LD_LSB   = 11;

   // status field positions
   localparam int unsigned ST_ROLL_BIT = 0;
   localparam int unsigned ST_CH0_BIT  = 1;
   localparam int unsigned ST_DIR_BIT  = 2;

   // reset values
   localparam logic [15:0] COUNT_RST  = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'h0000;
   localparam logic [15:0] CH0_RST    = 16'h0000;
   localparam logic [1:0]  LD_RST     = 2'h0;

   // maximum counts per length
   localparam logic [15:0] MAX_8  = 16'h00FF;
   localparam logic [15:0] MAX_10 = 16'h03FF;
   localparam logic [15:0] MAX_12 = 16'h0FFF;
   localparam logic [15:0] MAX_16 = 16'hFFFF;

   typedef enum logic [1:0] {MODE_STOP = 2'h0, MODE_UP = 2'h1, MODE_CONT = 2'h2, MODE_UPDN = 2'h3} pltc_mode_t;
   typedef enum logic [1:0] {LEN_16 = 2'h0, LEN_12 = 2'h1, LEN_10 = 2'h2, LEN_8 = 2'h3} pltc_len_t;
   typedef enum logic [1:0] {DIV_1 = 2'h0, DIV_2 = 2'h1, DIV_4 = 2'h2, DIV_8 = 2'h3} pltc_div_t;
   typedef enum logic [1:0] {SRC_AUX = 2'h0, SRC_SUBMAIN = 2'h1, SRC_EXT = 2'h2, SRC_ALT = 2'h3} pltc_src_t;

   // maximum count of a length code
   function automatic logic [15:0] len_max(input pltc_len_t l);
      unique case (l)
         LEN_16: len_max = MAX_16;
         LEN_12: len_max = MAX_12;
         LEN_10: len_max = MAX_10;
         LEN_8:  len_max = MAX_8;
      endcase
   endfunction
endpackage

// file: verilog/pltc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries clock selection down and timer ticks back up
interface pltc_tick_if;
   pltc_pkg::pltc_src_t src_sel;
   pltc_pkg::pltc_div_t div_sel;
   logic                clear;
   logic                tick;
   modport core (output src_sel, output div_sel, output clear, input tick);
   modport gen  (input src_sel, input div_sel, input clear, output tick);
endinterface
`default_nettype wire

// file: verilog/pltc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pltc_tick_gen (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] clk_pins,
   pltc_tick_if.gen        tif
);
   import pltc_pkg::*;

   typedef struct packed {
      logic [3:0] meta;
      logic [3:0] sync;
      logic [3:0] prev;
      logic [2:0] div;
      logic       tick;
   } pltc_gen_state_t;

   pltc_gen_state_t s_q;
   pltc_gen_state_t s_d;
   logic            edge_w;

   // mask of prescaler bits that must be all ones before a tick
   function automatic logic [2:0] div_mask(input pltc_div_t d);
      unique case (d)
         DIV_1: div_mask = 3'h0;
         DIV_2: div_mask = 3'h1;
         DIV_4: div_mask = 3'h3;
         DIV_8: div_mask = 3'h7;
      endcase
   endfunction

   // rising edge of the chosen pin; pins must run below pclk/2 or edges are lost
   assign edge_w = s_q.sync[tif.src_sel] & ~s_q.prev[tif.src_sel];

   // synchronise all pins, then divide the selected edges
   always_comb begin
      s_d      = s_q;
      s_d.meta = clk_pins;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
      s_d.tick = 1'b0;
      if (tif.clear) begin
         s_d.div = 3'h0;
      end else if (edge_w) begin
         if ((s_q.div & div_mask(tif.div_sel)) == div_mask(tif.div_sel)) begin
            s_d.tick = 1'b1;
            s_d.div  = 3'h0;
         end else begin
            s_d.div = 3'(s_q.div + 3'h1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tif.tick = s_q.tick;

   a_tick_needs_edge: assert property (@(posedge pclk) disable iff (!presetn)
      tif.tick |-> $past(edge_w)) else $error("tick without a source edge");
   a_clear_div_zero: assert property (@(posedge pclk) disable iff (!presetn)
      tif.clear |=> (s_q.div == 3'h0) && !tif.tick) else $error("clear did not reset prescaler");
endmodule
`default_nettype wire

// file: verilog/pltc_core.sv
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pltc_core #(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              aux_clock,
   input  wire logic              sub_main_clock,
   input  wire logic              external_timer_clock,
   input  wire logic              alternate_external_clock,
   output logic [15:0]            count_value,
   output logic [15:0]            period_latch,
   output logic                   channel_zero_equal,
   output logic                   rollover_flag,
   output logic                   channel_event_flag,
   output logic                   count_down,
   output logic                   irq
);
   import pltc_pkg::*;

   typedef struct packed {
      pltc_mode_t  mode;
      pltc_div_t   div;
      pltc_src_t   src;
      pltc_len_t   len;
      logic        rie;
      logic        cie;
      logic [1:0]  ld;
      logic [15:0] count;
      logic        dir_down;
      logic [15:0] ch0reg;
      logic [15:0] period;
      logic        roll;
      logic        chf;
      logic        eq;
      logic        irq;
      logic        clr;
      logic [31:0] rdata;
      logic        err;
   } pltc_state_t;

   pltc_state_t s_q;
   pltc_state_t s_d;
   pltc_tick_if tif ();

   logic [11:0] addr;
   logic        setup;
   logic        acc_wr;
   logic        wr_ctrl;
   logic        wr_cnt;
   logic        wr_ch0;
   logic        wr_st;
   logic        clr_req;
   logic [15:0] wdata16;
   logic [15:0] max_q;

   // bus decode; pready is always high in the access phase, so every transfer is zero-wait
   assign addr    = 12'(paddr);
   assign setup   = psel & ~penable;
   assign acc_wr  = psel & penable & pwrite;
   assign wr_ctrl = acc_wr && (addr == OFF_CTRL);
   assign wr_cnt  = acc_wr && (addr == OFF_COUNT);
   assign wr_ch0  = acc_wr && (addr == OFF_CH0);
   assign wr_st   = acc_wr && (addr == OFF_STATUS);
   assign clr_req = wr_ctrl & pwdata[CTRL_CLR_BIT];
   assign wdata16 = pwdata[15:0];
   assign max_q   = len_max(s_q.len);

   // clock selection and prescaler live in the tick generator
   assign tif.src_sel = s_q.src;
   assign tif.div_sel = s_q.div;
   assign tif.clear   = s_q.clr;

   pltc_tick_gen u_tick (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_pins ({alternate_external_clock, external_timer_clock, sub_main_clock, aux_clock}),
      .tif      (tif.gen)
   );

   // counting, software writes and flags
   always_comb begin
      logic [15:0] inc;
      logic [15:0] dec;
      logic        roll_ev;
      logic        eq_ev;
      logic        use_cont;
      logic        stepped;
      inc      = 16'(s_q.count + 16'h0001);
      dec      = 16'(s_q.count - 16'h0001);
      roll_ev  = 1'b0;
      eq_ev    = 1'b0;
      stepped  = 1'b0;
      // an out-of-range period in up/down mode degrades to free running
      use_cont = (s_q.mode == MODE_CONT) ||
                 ((s_q.mode == MODE_UPDN) && (s_q.period != 16'h0000) && (s_q.period > max_q));
      s_d      = s_q;
      s_d.clr  = 1'b0;
      s_d.eq   = 1'b0;

      // timer step, only on a tick and outside stop mode
      if (tif.tick && (s_q.mode != MODE_STOP)) begin
         stepped = 1'b1;
         if (use_cont) begin
            if (s_q.count >= max_q) begin
               s_d.count = 16'h0000;
               roll_ev   = (s_q.count == max_q);
            end else begin
               s_d.count = inc;
               eq_ev     = (inc == s_q.period);
            end
         end else if (s_q.period == 16'h0000) begin
            // zero period parks the counter so a new period starts upward from zero
            s_d.count    = 16'h0000;
            s_d.dir_down = 1'b0;
         end else if (s_q.mode == MODE_UP) begin
            if (s_q.count == s_q.period) begin
               s_d.count = 16'h0000;
               roll_ev   = 1'b1;
            end else if (s_q.count > s_q.period) begin
               // period shrank below the count, or up mode entered above it
               s_d.count = 16'h0000;
            end else begin
               s_d.count = inc;
               eq_ev     = (inc == s_q.period);
            end
         end else if (!s_q.dir_down) begin
            // up/down, rising half; a larger period simply extends it
            if (s_q.count < s_q.period) begin
               s_d.count = inc;
               eq_ev     = (inc == s_q.period);
            end else begin
               s_d.dir_down = 1'b1;
               s_d.count    = dec;
            end
         end else begin
            // up/down, falling half always runs on to zero
            if (s_q.count == 16'h0000) begin
               s_d.dir_down = 1'b0;
               s_d.count    = inc;
               eq_ev        = (inc == s_q.period);
            end else begin
               s_d.count = dec;
               if (dec == 16'h0000) begin
                  roll_ev      = 1'b1;
                  s_d.dir_down = 1'b0;
               end
            end
         end
      end

      // buffered period latch waits for the count to reach zero
      if (stepped && (s_q.ld != 2'h0) && (s_d.count == 16'h0000)) begin
         s_d.period = s_q.ch0reg;
      end

      // software writes; a count write overrides the stepped count but not the step's events, and raises none itself
      if (wr_ctrl) begin
         s_d.mode = pltc_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
         s_d.div  = pltc_div_t'(pwdata[CTRL_DIV_LSB +: 2]);
         s_d.src  = pltc_src_t'(pwdata[CTRL_SRC_LSB +: 2]);
         s_d.len  = pltc_len_t'(pwdata[CTRL_LEN_LSB +: 2]);
         s_d.rie  = pwdata[CTRL_RIE_BIT];
         s_d.cie  = pwdata[CTRL_CIE_BIT];
         s_d.ld   = pwdata[CTRL_LD_LSB +: 2];
      end
      if (wr_cnt) begin
         s_d.count = wdata16 & max_q;
      end
      if (wr_ch0) begin
         s_d.ch0reg = wdata16;
         if (s_q.ld == 2'h0) begin
            s_d.period = wdata16;
         end
      end
      if (clr_req) begin
         s_d.count    = 16'h0000;
         s_d.dir_down = 1'b0;
         s_d.clr      = 1'b1;
      end

      // write-one-to-clear, then a same-cycle event sets again
      if (wr_st) begin
         if (pwdata[ST_ROLL_BIT]) begin
            s_d.roll = 1'b0;
         end
         if (pwdata[ST_CH0_BIT]) begin
            s_d.chf = 1'b0;
         end
      end
      s_d.roll = s_d.roll | roll_ev;
      s_d.chf  = s_d.chf | eq_ev;
      s_d.eq   = eq_ev;
      s_d.irq  = (s_d.roll & s_d.rie) | (s_d.chf & s_d.cie);

      // read data is captured in the setup phase
      if (setup) begin
         s_d.rdata = 32'h00000000;
         s_d.err   = 1'b0;
         case (addr)
            OFF_CTRL: begin
               s_d.rdata[CTRL_MODE_LSB +: 2] = s_q.mode;
               s_d.rdata[CTRL_DIV_LSB +: 2]  = s_q.div;
               s_d.rdata[CTRL_SRC_LSB +: 2]  = s_q.src;
               s_d.rdata[CTRL_LEN_LSB +: 2]  = s_q.len;
               s_d.rdata[CTRL_RIE_BIT]       = s_q.rie;
               s_d.rdata[CTRL_CIE_BIT]       = s_q.cie;
               s_d.rdata[CTRL_LD_LSB +: 2]   = s_q.ld;
            end
            OFF_COUNT: begin
               s_d.rdata[15:0] = s_q.count;
            end
            OFF_CH0: begin
               s_d.rdata[15:0] = s_q.ch0reg;
            end
            OFF_PERIOD: begin
               s_d.rdata[15:0] = s_q.period;
            end
            OFF_STATUS: begin
               s_d.rdata[ST_ROLL_BIT] = s_q.roll;
               s_d.rdata[ST_CH0_BIT]  = s_q.chf;
               s_d.rdata[ST_DIR_BIT]  = s_q.dir_down;
            end
            default: begin
               s_d.err = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{mode: MODE_STOP, div: DIV_1, src: SRC_AUX, len: LEN_16, ld: LD_RST,
                  count: COUNT_RST, ch0reg: CH0_RST, period: PERIOD_RST, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs other than pready and pslverr come straight from the state register
   assign pready             = psel & penable;
   assign pslverr            = psel & penable & s_q.err;
   assign prdata             = s_q.rdata;
   assign count_value        = s_q.count;
   assign period_latch       = s_q.period;
   assign channel_zero_equal = s_q.eq;
   assign rollover_flag      = s_q.roll;
   assign channel_event_flag = s_q.chf;
   assign count_down         = s_q.dir_down;
   assign irq                = s_q.irq;

   a_clear_zeroes: assert property (@(posedge pclk) disable iff (!presetn)
      clr_req |=> (count_value == 16'h0000) && !count_down && tif.clear) else $error("clear left state");
   a_count_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cnt && !clr_req) |=> count_value == ($past(wdata16) & $past(max_q))) else $error("count write wrong");
   a_write_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cnt && !tif.tick && !rollover_flag) |=> !rollover_flag) else $error("write raised rollover");
   a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.mode == MODE_STOP && !acc_wr) |=> $stable(count_value)) else $error("stopped timer moved");
   a_cont_step: assert property (@(posedge pclk) disable iff (!presetn)
      (tif.tick && s_q.mode == MODE_CONT && !acc_wr && count_value < max_q)
      |=> count_value == 16'($past(count_value) + 16'h0001)) else $error("continuous step wrong");
   a_cont_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (tif.tick && s_q.mode == MODE_CONT && !acc_wr && count_value == max_q)
      |=> (count_value == 16'h0000) && rollover_flag) else $error("continuous wrap wrong");
   a_up_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (tif.tick && s_q.mode == MODE_UP && !acc_wr && period_latch != 16'h0000 && count_value == period_latch)
      |=> (count_value == 16'h0000) && rollover_flag) else $error("up wrap wrong");
   a_zero_halt: assert property (@(posedge pclk) disable iff (!presetn)
      (tif.tick && s_q.mode == MODE_UP && !acc_wr && period_latch == 16'h0000)
      |=> count_value == 16'h0000) else $error("zero period did not halt");
   a_updn_turn: assert property (@(posedge pclk) disable iff (!presetn)
      (tif.tick && s_q.mode == MODE_UPDN && !acc_wr && !count_down && period_latch != 16'h0000 &&
       period_latch <= max_q && count_value == period_latch)
      |=> count_down && (count_value == 16'($past(count_value) - 16'h0001))) else $error("no turn at period");
   // a zero or out-of-range period takes the halt or free-running branch instead
   a_updn_roll: assert property (@(posedge pclk) disable iff (!presetn)
      (tif.tick && s_q.mode == MODE_UPDN && !acc_wr && count_down && count_value == 16'h0001 &&
       period_latch != 16'h0000 && period_latch <= max_q)
      |=> (count_value == 16'h0000) && rollover_flag && !count_down) else $error("down roll wrong");
   a_period_load: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ch0 && s_q.ld == 2'h0) |=> period_latch == $past(wdata16)) else $error("period not loaded");
   a_irq_rollover: assert property (@(posedge pclk) disable iff (!presetn)
      (rollover_flag && s_q.rie) |-> irq) else $error("rollover interrupt missing");
endmodule
`default_nettype wire

// file: verification/test_programmable_length_timer_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_programmable_length_timer_core;
   import pltc_pkg::*;

   // one table row: setup, source edges, expected count and status bits {dir, ch, roll}
   typedef struct {
      pltc_mode_t  mode;
      pltc_div_t   div;
      pltc_src_t   src;
      pltc_len_t   len;
      logic [15:0] period;
      logic [15:0] start;
      int          edges;
      logic [15:0] exp_cnt;
      logic [2:0]  exp_st;
   } pltc_row_t;

   logic        pclk;
   logic        presetn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  pins;
   logic [15:0] count_value;
   logic [15:0] period_latch;
   logic        channel_zero_equal;
   int          eq_cnt = 0;
   logic        rollover_flag;
   logic        channel_event_flag;
   logic        count_down;
   logic        irq;
   logic [31:0] rd_data;
   logic        rd_err;
   int          fails;
   int          compares;
   pltc_row_t   rows[$];
   logic [11:0] regs [5] = '{OFF_CTRL, OFF_COUNT, OFF_CH0, OFF_PERIOD, OFF_STATUS};

   pltc_core #(.ADDR_W(12)) pltc_core_i (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .paddr                    (paddr),
      .psel                     (psel),
      .penable                  (penable),
      .pwrite                   (pwrite),
      .pwdata                   (pwdata),
      .prdata                   (prdata),
      .pready                   (pready),
      .pslverr                  (pslverr),
      .aux_clock                (pins[0]),
      .sub_main_clock           (pins[1]),
      .external_timer_clock     (pins[2]),
      .alternate_external_clock (pins[3]),
      .count_value              (count_value),
      .period_latch             (period_latch),
      .channel_zero_equal       (channel_zero_equal),
      .rollover_flag            (rollover_flag),
      .channel_event_flag       (channel_event_flag),
      .count_down               (count_down),
      .irq                      (irq)
   );

   // 25 MHz bus clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // the equal pulse lasts one cycle, so count every pulse instead of sampling it
   always @(posedge pclk) begin
      eq_cnt <= eq_cnt + int'(channel_zero_equal === 1'b1);
   end

   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t word got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_b(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         $display("[ERR] %0t bus answer missing", $time);
         give_verdict();
      end
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] ctrl(input pltc_mode_t m, input pltc_div_t dv, input pltc_src_t s,
                                        input pltc_len_t l, input logic clr, input logic rie);
      ctrl = 32'h0;
      ctrl[CTRL_MODE_LSB +: 2] = m;
      ctrl[CTRL_DIV_LSB +: 2]  = dv;
      ctrl[CTRL_SRC_LSB +: 2]  = s;
      ctrl[CTRL_LEN_LSB +: 2]  = l;
      ctrl[CTRL_CLR_BIT]       = clr;
      ctrl[CTRL_RIE_BIT]       = rie;
   endfunction

   function automatic pltc_row_t mk(input pltc_mode_t m, input pltc_div_t dv, input pltc_src_t s,
                                    input pltc_len_t l, input logic [15:0] p, input logic [15:0] st,
                                    input int e, input logic [15:0] c, input logic [2:0] f);
      mk = '{m, dv, s, l, p, st, e, c, f};
   endfunction

   // selected pin gets n rising edges; the next pin gets twice as many as a decoy
   task automatic pulse(input pltc_src_t src, input int n);
      int d;
      d = (int'(src) + 1) % 4;
      repeat (n) begin
         for (int c = 0; c < 8; c++) begin
            @(posedge pclk);
            pins[src] <= (c < 4);
            pins[d]   <= (c % 4 < 2);
         end
      end
      // the pin path is synchronised, so give the tick time to land
      repeat (12) @(posedge pclk);
   endtask

   task automatic rd_cnt(input logic [15:0] exp);
      apb(1'b0, OFF_COUNT, 32'h0);
      chk_w(rd_data, {16'h0000, exp});
   endtask

   // clear keeps the prescaler phase known, so edge counts map to whole ticks
   task automatic run_row(input pltc_row_t r);
      apb(1'b1, OFF_CTRL, ctrl(MODE_STOP, r.div, r.src, r.len, 1'b1, 1'b0));
      apb(1'b1, OFF_STATUS, 32'h0000_0003);
      apb(1'b1, OFF_CH0, {16'h0000, r.period});
      apb(1'b1, OFF_COUNT, {16'h0000, r.start});
      apb(1'b1, OFF_CTRL, ctrl(r.mode, r.div, r.src, r.len, 1'b0, 1'b0));
      pulse(r.src, r.edges);
      rd_cnt(r.exp_cnt);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk_w(rd_data, {29'h0, r.exp_st});
   endtask

   initial begin
      fails    = 0;
      compares = 0;
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0;
      pins     = 4'h0;
      rows.push_back(mk(MODE_UP, DIV_1, SRC_AUX, LEN_16, 16'h0005, 16'h0000, 6, 16'h0000, 3'h3));
      rows.push_back(mk(MODE_UP, DIV_2, SRC_SUBMAIN, LEN_16, 16'h0005, 16'h0000, 8, 16'h0004, 3'h0));
      rows.push_back(mk(MODE_CONT, DIV_4, SRC_EXT, LEN_8, 16'h0010, 16'h00FE, 8, 16'h0000, 3'h1));
      rows.push_back(mk(MODE_CONT, DIV_8, SRC_ALT, LEN_12, 16'h0010, 16'h0FFE, 16, 16'h0000, 3'h1));
      rows.push_back(mk(MODE_CONT, DIV_1, SRC_AUX, LEN_10, 16'h0010, 16'h03FF, 1, 16'h0000, 3'h1));
      rows.push_back(mk(MODE_CONT, DIV_1, SRC_AUX, LEN_16, 16'h0010, 16'hFFFF, 1, 16'h0000, 3'h1));
      rows.push_back(mk(MODE_UPDN, DIV_1, SRC_AUX, LEN_16, 16'h0003, 16'h0000, 5, 16'h0001, 3'h6));
      rows.push_back(mk(MODE_UPDN, DIV_1, SRC_AUX, LEN_16, 16'h0003, 16'h0000, 7, 16'h0001, 3'h3));
      rows.push_back(mk(MODE_UP, DIV_1, SRC_AUX, LEN_16, 16'h0004, 16'h000A, 1, 16'h0000, 3'h0));
      rows.push_back(mk(MODE_CONT, DIV_1, SRC_AUX, LEN_16, 16'h0003, 16'h0002, 3, 16'h0005, 3'h2));
      rows.push_back(mk(MODE_UPDN, DIV_1, SRC_AUX, LEN_8, 16'h0100, 16'h00FE, 3, 16'h0001, 3'h1));
      rows.push_back(mk(MODE_STOP, DIV_1, SRC_SUBMAIN, LEN_16, 16'h0005, 16'h0007, 3, 16'h0007, 3'h0));
      rows.push_back(mk(MODE_STOP, DIV_1, SRC_AUX, LEN_8, 16'h0005, 16'h1234, 0, 16'h0034, 3'h0));
      rows.push_back(mk(MODE_UP, DIV_1, SRC_AUX, LEN_16, 16'h0005, 16'h0005, 0, 16'h0005, 3'h0));
      rows.push_back(mk(MODE_UP, DIV_1, SRC_AUX, LEN_16, 16'h0000, 16'h0005, 2, 16'h0000, 3'h0));
      // reset: count and irq low while held, every register reads zero after release
      repeat (10) @(posedge pclk);
      chk_w({16'h0000, count_value}, 32'h0);
      chk_b(irq, 1'b0);
      presetn <= 1'b1;
      foreach (regs[i]) begin
         apb(1'b0, regs[i], 32'h0);
         chk_w(rd_data, 32'h0);
      end
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      // nonzero period after a zero one restarts upward from zero
      apb(1'b1, OFF_CH0, 32'h0000_0004);
      pulse(SRC_AUX, 2);
      rd_cnt(16'h0002);
      chk_w({16'h0000, period_latch}, 32'h4);
      // period raised while running extends the count, then lowered below it wraps
      run_row(mk(MODE_UP, DIV_1, SRC_AUX, LEN_16, 16'h000A, 16'h0000, 6, 16'h0006, 3'h0));
      apb(1'b1, OFF_CH0, 32'h0000_0014);
      pulse(SRC_AUX, 8);
      rd_cnt(16'h000E);
      apb(1'b1, OFF_CH0, 32'h0000_0003);
      pulse(SRC_AUX, 2);
      apb(1'b0, OFF_COUNT, 32'h0);
      chk_b(rd_data < 32'h2, 1'b1);
      apb(1'b1, OFF_COUNT, 32'h0000_0002);
      @(posedge pclk);
      #1;
      chk_w({16'h0000, count_value}, 32'h2);
      // direction survives a stop and a clear resets it
      run_row(mk(MODE_UPDN, DIV_1, SRC_AUX, LEN_16, 16'h0003, 16'h0000, 4, 16'h0002, 3'h6));
      apb(1'b1, OFF_CTRL, ctrl(MODE_STOP, DIV_1, SRC_AUX, LEN_16, 1'b0, 1'b0));
      pulse(SRC_AUX, 2);
      rd_cnt(16'h0002);
      apb(1'b1, OFF_CTRL, ctrl(MODE_UPDN, DIV_1, SRC_AUX, LEN_16, 1'b0, 1'b0));
      pulse(SRC_AUX, 1);
      rd_cnt(16'h0001);
      chk_b(count_down, 1'b1);
      chk_b(channel_event_flag, 1'b1);
      apb(1'b1, OFF_CTRL, ctrl(MODE_STOP, DIV_1, SRC_AUX, LEN_16, 1'b1, 1'b0));
      @(posedge pclk);
      #1;
      chk_w({16'h0000, count_value}, 32'h0);
      chk_b(count_down, 1'b0);
      // rollover request masked, then enabled, then cleared by software
      run_row(mk(MODE_CONT, DIV_1, SRC_AUX, LEN_8, 16'h0010, 16'h00FF, 1, 16'h0000, 3'h1));
      chk_b(irq, 1'b0);
      apb(1'b1, OFF_CTRL, ctrl(MODE_CONT, DIV_1, SRC_AUX, LEN_8, 1'b0, 1'b1));
      @(posedge pclk);
      #1;
      chk_b(irq, 1'b1);
      apb(1'b1, OFF_STATUS, 32'h0000_0001);
      @(posedge pclk);
      #1;
      chk_b(rollover_flag, 1'b0);
      chk_b(irq, 1'b0);
      // five counted arrivals at the period across all scenarios
      chk_w(eq_cnt, 32'h5);
      // a second reset in mid-run drops count and control back to zero
      apb(1'b1, OFF_COUNT, 32'h0000_0055);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk_w({16'h0000, count_value}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, OFF_CTRL, 32'h0);
      chk_w(rd_data, 32'h0);
      // an unmapped offset is refused with an error and reads zero
      apb(1'b0, 12'h020, 32'h0);
      chk_b(rd_err, 1'b1);
      chk_w(rd_data, 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
